// >>> pkg/qbt_pkg.sv
// package: register map, field layout, reset values and helpers of the bus transceiver
`default_nettype none
package qbt_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int LANES = 4;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_TXWORD = 12'h004;
  localparam logic [11:0] ADDR_PULSE  = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_DRV_EN_N_BIT  = 0;
  localparam int CTRL_HOLD_BIT      = 1;
  localparam int CTRL_RCV_OE_N_BIT  = 2;
  localparam int CTRL_DRV_CLK_BIT   = 3;
  localparam int CTRL_WIDTH         = 4;
  localparam logic [3:0] CTRL_RESET = 4'h5;

  // ----------------------------------------------------------------
  // pulse command and status fields
  // ----------------------------------------------------------------
  localparam int PULSE_FIRE_BIT     = 0;
  localparam int STAT_LATCH_LSB     = 0;
  localparam int STAT_DRVREG_LSB    = 4;
  localparam int STAT_BUS_LSB       = 8;
  localparam int STAT_PARITY_BIT    = 12;
  localparam int STAT_CHECK_BIT     = 13;

  // ----------------------------------------------------------------
  // reset values of datapath state
  // ----------------------------------------------------------------
  localparam logic [3:0] TXWORD_RESET = 4'h0;
  localparam logic [3:0] DRVREG_RESET = 4'h0;
  localparam logic [3:0] LATCH_RESET  = 4'h0;

  // odd parity output: exclusive-or of the selected four bits
  function automatic logic oddParity(input logic [LANES-1:0] word);
    oddParity = ^word;
  endfunction

endpackage
`default_nettype wire

// >>> pkg/qbt_ctl_if.sv
// interface: control and status between register file and transceiver core
`default_nettype none
interface qbt_ctl_if;
  import qbt_pkg::*;
  logic [LANES-1:0] txWord;
  logic             driverClk;
  logic             drvEnN;
  logic             latchHold;
  logic             rcvOeN;
  logic [LANES-1:0] drvReg;
  logic [LANES-1:0] latchQ;
  logic             parity;

  modport regs (output txWord, output driverClk, output drvEnN, output latchHold,
                output rcvOeN, input drvReg, input latchQ, input parity);
  modport core (input txWord, input driverClk, input drvEnN, input latchHold,
                input rcvOeN, output drvReg, output latchQ, output parity);
endinterface
`default_nettype wire

// >>> verilog/qbt_xcvr_core.sv
// transceiver core: driver register, bus drivers, receive latches, parity unit
`default_nettype none
module qbt_xcvr_core
  import qbt_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // control from the register file
  qbt_ctl_if.core               ctl,
  // shared bus lines
  input  wire logic [LANES-1:0] busIn,
  output logic      [LANES-1:0] busOut,
  output logic      [LANES-1:0] busOe,
  // receive outputs and parity
  output logic      [LANES-1:0] rcvOut,
  output logic      [LANES-1:0] rcvOe,
  output logic                  parityOut
);

  logic [LANES-1:0] drvReg_q;
  logic [LANES-1:0] latch_q;
  logic             clkPrev_q;
  logic             parity_q;
  logic             clkRise;

  // ----------------------------------------------------------------
  // driver register
  // ----------------------------------------------------------------
  // a steady driver clock level never loads, only a low-to-high step
  assign clkRise = ctl.driverClk & ~clkPrev_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= ctl.driverClk;
    end
  end

  // reset value only gives simulation a known start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drvReg_q <= DRVREG_RESET;
    end else if (clkRise) begin
      drvReg_q <= ctl.txWord;
    end
  end

  // ----------------------------------------------------------------
  // bus drivers
  // ----------------------------------------------------------------
  assign busOut = ~drvReg_q;
  assign busOe  = {LANES{~ctl.drvEnN}};

  // ----------------------------------------------------------------
  // receive latches
  // ----------------------------------------------------------------
  // receivers see the line even while we drive it, so own data reads back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_q <= LATCH_RESET;
    end else if (!ctl.latchHold) begin
      latch_q <= ~busIn;
    end
  end // hold keeps contents whatever the bus does

  assign rcvOut = latch_q;
  assign rcvOe  = {LANES{~ctl.rcvOeN}};

  // ----------------------------------------------------------------
  // parity unit
  // ----------------------------------------------------------------
  // generate from the inputs, not the stored word, so it leads the bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      parity_q <= 1'b0;
    end else if (ctl.drvEnN) begin
      parity_q <= oddParity(latch_q);
    end else begin
      parity_q <= oddParity(ctl.txWord);
    end
  end

  assign parityOut  = parity_q;
  assign ctl.drvReg = drvReg_q;
  assign ctl.latchQ = latch_q;
  assign ctl.parity = parity_q;

endmodule
`default_nettype wire

// >>> verilog/qbt_transceiver.sv
// top: quad bus transceiver with parity, registers reached over AHB-Lite
//
// Contract
// - driver register loads word on driver clock rise
// - driven bus line is inverse of register bit
// - enable high floats drivers, low drives bus
// - each line feeds its receiver, inverted, always
// - receive latch path: bus inverted, word non-inverted
// - hold low: latches transparent, follow inverted bus; here a clocked register that follows one clock behind
// - hold high: latches keep contents regardless
// - output enable high floats receive outputs
// - drive enabled: parity from transmit inputs
// - drive disabled: parity from latch contents
// - parity is exclusive-or of selected bits
// - driver register changes only on rising edge
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`default_nettype none
module qbt_transceiver
  import qbt_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  // shared bus lines
  input  wire logic [LANES-1:0] busIn,
  output logic      [LANES-1:0] busOut,
  output logic      [LANES-1:0] busOe,
  // receive outputs and parity
  output logic      [LANES-1:0] rcvOut,
  output logic      [LANES-1:0] rcvOe,
  output logic                  parityOut
);

  qbt_ctl_if ctl ();

  logic [11:0]           addr_q;
  logic                  wrPend_q;
  logic                  rdPend_q;
  logic [31:0]           hrdata_q;
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [LANES-1:0]      txWord_q;
  logic                  pulse_q;
  logic                  addrTaken;
  logic                  wrNow;
  logic [31:0]           readMux;

  // ----------------------------------------------------------------
  // bus slave: address phase
  // ----------------------------------------------------------------
  assign addrTaken = hsel & htrans[1] & hready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q   <= 12'h000;
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
    end else begin
      if (addrTaken) begin
        addr_q <= haddr[11:0];
      end
      wrPend_q <= addrTaken & hwrite;
      rdPend_q <= addrTaken & ~hwrite;
    end
  end

  // reads take one wait state so a write just before is seen
  assign hreadyout = ~rdPend_q;
  assign hresp     = 1'b0;
  assign wrNow     = wrPend_q;

  // ----------------------------------------------------------------
  // register file: writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrNow && addr_q == ADDR_CTRL) begin
      ctrl_q <= hwdata[CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txWord_q <= TXWORD_RESET;
    end else if (wrNow && addr_q == ADDR_TXWORD) begin
      txWord_q <= hwdata[LANES-1:0];
    end
  end

  // one-cycle driver clock pulse; no edge if the level bit is already high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= wrNow && addr_q == ADDR_PULSE && hwdata[PULSE_FIRE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // register file: reads
  // ----------------------------------------------------------------
  always_comb begin
    readMux = 32'h0000_0000;
    unique case (addr_q)
      ADDR_CTRL: begin
        readMux[CTRL_WIDTH-1:0] = ctrl_q;
      end
      ADDR_TXWORD: begin
        readMux[LANES-1:0] = txWord_q;
      end
      ADDR_STATUS: begin
        readMux[STAT_LATCH_LSB +: LANES]  = ctl.latchQ;
        readMux[STAT_DRVREG_LSB +: LANES] = ctl.drvReg;
        readMux[STAT_BUS_LSB +: LANES]    = busIn;
        readMux[STAT_PARITY_BIT]          = ctl.parity;
        readMux[STAT_CHECK_BIT]           = ctrl_q[CTRL_DRV_EN_N_BIT];
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rdPend_q) begin
      hrdata_q <= readMux;
    end
  end

  assign hrdata = hrdata_q;

  // ----------------------------------------------------------------
  // control to the core
  // ----------------------------------------------------------------
  // only one transceiver per line may enable, the bus partner sees to it
  assign ctl.txWord    = txWord_q;
  assign ctl.driverClk = ctrl_q[CTRL_DRV_CLK_BIT] | pulse_q;
  assign ctl.drvEnN    = ctrl_q[CTRL_DRV_EN_N_BIT];
  assign ctl.latchHold = ctrl_q[CTRL_HOLD_BIT];
  assign ctl.rcvOeN    = ctrl_q[CTRL_RCV_OE_N_BIT];

  qbt_xcvr_core u_core (
    .clk       (clk),
    .nrst      (nrst),
    .ctl       (ctl),
    .busIn     (busIn),
    .busOut    (busOut),
    .busOe     (busOe),
    .rcvOut    (rcvOut),
    .rcvOe     (rcvOe),
    .parityOut (parityOut)
  );

endmodule
`default_nettype wire

// >>> test/qbt_bus_partner.sv
// far side model: another transceiver on the shared lines, terminated high
`default_nettype none
module qbt_bus_partner
  import qbt_pkg::*;
(
  // bench control
  input  wire logic             drvOn,
  input  wire logic [LANES-1:0] drvVal,
  // device side of the lines
  input  wire logic [LANES-1:0] devOut,
  input  wire logic [LANES-1:0] devOe,
  // resolved line level
  output logic      [LANES-1:0] busLvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ownDrv;
  // never drive while the device drives, so no line is fought over
  assign ownDrv = drvOn && (devOe == 4'h0);
  // released lines float to the termination level, not the last value
  assign busLvl = (devOut & devOe) | (~devOe & (ownDrv ? drvVal : 4'hF));
endmodule
`default_nettype wire

// >>> test/qbt_transceiver_asserts.sv
// checker: datapath relations at the transceiver's top ports
`default_nettype none
module qbt_transceiver_asserts
  import qbt_pkg::*;
(
  // clock and reset
  input wire logic             clk,
  input wire logic             nrst,
  // bus slave inputs
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  // datapath
  input wire logic [LANES-1:0] busIn,
  input wire logic [LANES-1:0] busOut,
  input wire logic [LANES-1:0] busOe,
  input wire logic [LANES-1:0] rcvOut,
  input wire logic [LANES-1:0] rcvOe,
  input wire logic             parityOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // shadow of written control and word
  // ----------------------------------------------------------------
  logic             wrPend_q;
  logic [11:0]      wrAddr_q;
  logic [3:0]       ctrl_q;
  logic [LANES-1:0] tx_q;
  logic             wrNow;
  assign wrNow = wrPend_q && hready;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
    end else if (hready) begin
      wrPend_q <= hsel && htrans[1] && hwrite;
      wrAddr_q <= haddr[11:0];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
      tx_q   <= TXWORD_RESET;
    end else begin
      if (wrNow && wrAddr_q == ADDR_CTRL) ctrl_q <= hwdata[3:0];
      if (wrNow && wrAddr_q == ADDR_TXWORD) tx_q <= hwdata[3:0];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_load;
    wrNow && wrAddr_q == ADDR_PULSE && hwdata[PULSE_FIRE_BIT] && !ctrl_q[3]
      |=> ##1 busOut == ~$past(tx_q);
  endproperty
  a_load: assert property (p_load) else $error("driver word not loaded");
  property p_drv_hold;
    $changed(busOut) |-> $past(wrPend_q, 2);
  endproperty
  a_drv_hold: assert property (p_drv_hold) else $error("driver changed unclocked");
  property p_bus_oe;
    busOe == {LANES{~ctrl_q[CTRL_DRV_EN_N_BIT]}};
  endproperty
  a_bus_oe: assert property (p_bus_oe) else $error("bus enable wrong");
  property p_rcv_oe;
    rcvOe == {LANES{~ctrl_q[CTRL_RCV_OE_N_BIT]}};
  endproperty
  a_rcv_oe: assert property (p_rcv_oe) else $error("receive enable wrong");
  property p_follow;
    !ctrl_q[CTRL_HOLD_BIT] |=> rcvOut == ~$past(busIn);
  endproperty
  a_follow: assert property (p_follow) else $error("latch not following");
  property p_hold;
    ctrl_q[CTRL_HOLD_BIT] |=> $stable(rcvOut);
  endproperty
  a_hold: assert property (p_hold) else $error("latch not holding");
  property p_par_chk;
    ctrl_q[CTRL_DRV_EN_N_BIT] |=> parityOut == ^$past(rcvOut);
  endproperty
  a_par_chk: assert property (p_par_chk) else $error("check parity wrong");
  property p_par_gen;
    !ctrl_q[CTRL_DRV_EN_N_BIT] |=> parityOut == ^$past(tx_q);
  endproperty
  a_par_gen: assert property (p_par_gen) else $error("generate parity wrong");
endmodule
bind qbt_transceiver qbt_transceiver_asserts u_chk (
  .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .busIn(busIn), .busOut(busOut), .busOe(busOe),
  .rcvOut(rcvOut), .rcvOe(rcvOe), .parityOut(parityOut)
);
`default_nettype wire

// >>> test/qbt_transceiver_tb.sv
// testbench: register-driven scenarios for the quad bus transceiver
`default_nettype none
module qbt_transceiver_tb
  import qbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;
  logic             nrst, hsel, hwrite, hready, hresp, parityOut, pOn;
  logic [31:0]      haddr, hwdata, hrdata, d;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [LANES-1:0] busIn, busOut, busOe, rcvOut, rcvOe, pVal;
  int               num_errors = 0;
  int               total_checks = 0;
  always #50 clk = ~clk;
  qbt_transceiver DUT (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .busIn(busIn), .busOut(busOut), .busOe(busOe), .rcvOut(rcvOut),
    .rcvOe(rcvOe), .parityOut(parityOut));
  qbt_bus_partner u_far (
    .drvOn(pOn), .drvVal(pVal), .devOut(busOut), .devOe(busOe), .busLvl(busIn));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ready is looked at mid-cycle, where it already holds its edge value
  task automatic waitRdy(output logic [31:0] rd);
    int   n;
    logic r;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      rd = hrdata;
      r = hready;
      @(posedge clk);
      if (r === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rw(input logic [11:0] a, input logic w, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitRdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy(rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {nrst, hsel, hwrite, pOn} = 4'h0;
    {haddr, hwdata, htrans, pVal} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rw(ADDR_CTRL, 1'b0, 32'h0, d);
    chk("ctrl", d, {28'h0, CTRL_RESET});
    chk("busOe", busOe, 4'h0);
    chk("rcvOe", rcvOe, 4'h0);
    chk("busOut", busOut, 4'hF);
    chk("rcvOut", rcvOut, 4'h0);
    chk("parity", parityOut, 1'b0);
    rw(ADDR_TXWORD, 1'b1, 32'hA, d);
    rw(ADDR_PULSE, 1'b1, 32'h1, d);
    wt(3);
    chk("busOut", busOut, 4'h5);
    rw(ADDR_TXWORD, 1'b1, 32'h3, d);
    wt(3);
    chk("busOut", busOut, 4'h5);
    rw(ADDR_CTRL, 1'b1, 32'h0, d);
    wt(4);
    chk("busOe", busOe, 4'hF);
    chk("rcvOe", rcvOe, 4'hF);
    chk("rcvOut", rcvOut, 4'hA);
    chk("parity", parityOut, 1'b0);
    rw(ADDR_TXWORD, 1'b1, 32'h7, d);
    wt(3);
    chk("parity", parityOut, 1'b1);
    rw(ADDR_CTRL, 1'b1, 32'h1, d);
    pOn <= 1'b1;
    pVal <= 4'h3;
    wt(4);
    chk("busOe", busOe, 4'h0);
    chk("rcvOut", rcvOut, 4'hC);
    chk("parity", parityOut, 1'b0);
    rw(ADDR_CTRL, 1'b1, 32'h3, d);
    pVal <= 4'h9;
    wt(4);
    chk("rcvOut", rcvOut, 4'hC);
    rw(ADDR_CTRL, 1'b1, 32'h7, d);
    wt(2);
    chk("rcvOe", rcvOe, 4'h0);
    pOn <= 1'b0;
    rw(ADDR_CTRL, 1'b1, 32'h5, d);
    wt(4);
    chk("rcvOut", rcvOut, 4'h0);
    chk("parity", parityOut, 1'b0);
    rw(12'h010, 1'b0, 32'h0, d);
    chk("unmapped", d, 32'h0);
    chk("hresp", hresp, 1'b0);
    // status: check mode, bus released high, driver word A, latch 0
    rw(ADDR_STATUS, 1'b0, 32'h0, d);
    chk("status", d, 32'h0000_2FA0);
    // level-driven driver clock: a low-to-high step of the bit loads
    rw(ADDR_TXWORD, 1'b1, 32'h6, d);
    rw(ADDR_CTRL, 1'b1, 32'hD, d);
    wt(3);
    chk("busOut", busOut, 4'h9);
    // pulse while the level is already high gives no edge
    rw(ADDR_TXWORD, 1'b1, 32'h1, d);
    rw(ADDR_PULSE, 1'b1, 32'h1, d);
    wt(3);
    chk("busOut", busOut, 4'h9);
    rw(ADDR_STATUS, 1'b0, 32'h0, d);
    chk("status", d, 32'h0000_2F60);
    finish_test();
  end
endmodule
`default_nettype wire
